/* core/swd_pkg.sv */
// Constants, types and opcode ranges for the status word and opcode dispatch block.
package swd_pkg;
	// Status byte bit positions.
	localparam int STS_GATE_BIT = 7;
	localparam int STS_TRACE_BIT = 4;
	localparam int STS_N_BIT = 3;
	localparam int STS_Z_BIT = 2;
	localparam int STS_V_BIT = 1;
	localparam int STS_C_BIT = 0;
	localparam logic [7:0] STS_WORKING_MASK = 8'h9F;
	localparam logic [7:0] STS_RESET = 8'h00;

	// Opcode ranges written in hex.
	localparam logic [15:0] OP_DIAG_LO = 16'h0088;
	localparam logic [15:0] OP_DIAG_HI = 16'h008F;
	localparam logic [15:0] OP_U3000_LO = 16'h0090;
	localparam logic [15:0] OP_U3000_HI = 16'h0097;
	localparam logic [15:0] OP_U3003_LO = 16'h7A20;
	localparam logic [15:0] OP_U3003_HI = 16'h7BFF;
	localparam logic [15:0] OP_U3001_LO = 16'h7C00;
	localparam logic [15:0] OP_U3001_HI = 16'h7DFF;
	localparam logic [15:0] OP_USER_LO = 16'h7DC0;
	localparam logic [15:0] OP_CCOP_LO = 16'h00A0;
	localparam logic [15:0] OP_CCOP_HI = 16'h00BF;
	localparam logic [15:0] OP_MISC_HI = 16'h0007;
	localparam logic [15:0] OP_JMP_LO = 16'h0040;
	localparam logic [15:0] OP_RTS_HI = 16'h0087;
	localparam logic [15:0] OP_BR_LO = 16'h0100;
	localparam logic [15:0] OP_BR_HI = 16'h07FF;
	localparam logic [15:0] OP_JSR_LO = 16'h0800;
	localparam logic [15:0] OP_JSR_HI = 16'h09FF;
	localparam logic [15:0] OP_SOB_LO = 16'h7E00;
	localparam logic [15:0] OP_SOB_HI = 16'h7FFF;
	localparam logic [15:0] OP_BRB_LO = 16'h8000;
	localparam logic [15:0] OP_BRB_HI = 16'h87FF;
	localparam logic [15:0] OP_EMT_LO = 16'h8800;
	localparam logic [15:0] OP_EMT_HI = 16'h89FF;
	localparam logic [15:0] OP_RTI = 16'h0002;
	localparam logic [15:0] OP_BPT = 16'h0003;
	localparam logic [15:0] OP_IOT = 16'h0004;
	localparam logic [15:0] OP_RTT = 16'h0006;
	localparam logic [15:0] OP_MASK_DD = 16'hFFC0;
	localparam logic [15:0] OP_MOVE_FROM_STATUS = 16'h8DC0;
	localparam logic [15:0] OP_MOVE_TO_STATUS = 16'h8D00;

	// Microaddresses in the user control store and trap vectors.
	localparam logic [10:0] UADDR_3000 = 11'h600;
	localparam logic [10:0] UADDR_3001 = 11'h601;
	localparam logic [10:0] UADDR_3003 = 11'h603;
	localparam logic [15:0] RESV_VECTOR = 16'h0008;
	localparam logic [15:0] VECTOR_STEP = 16'h0002;

	// Addressing mode codes and dedicated registers.
	localparam logic [2:0] MODE_REG = 3'h0;
	localparam logic [2:0] MODE_AUTOINC = 3'h2;
	localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
	localparam logic [2:0] MODE_INDEX = 3'h6;
	localparam logic [2:0] REG_SP = 3'h6;
	localparam logic [2:0] REG_PC = 3'h7;
	localparam logic [2:0] DOUBLE_NONE = 3'h0;
	localparam logic [2:0] DOUBLE_EXT = 3'h7;

	// Instruction classes.
	typedef enum logic [2:0] {
		SWD_CLS_DATA = 3'b000,
		SWD_CLS_CTRL = 3'b001,
		SWD_CLS_TRAP = 3'b010,
		SWD_CLS_STATUS = 3'b011,
		SWD_CLS_RESV = 3'b100
	} swd_class_t;

	// Decode result for one instruction.
	typedef struct packed {
		swd_class_t cls;
		logic dispatch;
		logic [10:0] micro_addr;
		logic [5:0] user_field;
		logic user_defined;
		logic resv_trap;
		logic diag_store;
		logic [2:0] diag_reg;
	} swd_decode_t;

	// Operand addressing description.
	typedef struct packed {
		logic has_src;
		logic [2:0] src_mode;
		logic [2:0] src_reg;
		logic src_pc_rel;
		logic has_dst;
		logic [2:0] dst_mode;
		logic [2:0] dst_reg;
		logic dst_pc_rel;
	} swd_addr_t;
endpackage : swd_pkg

/* core/swd_status_dispatch.sv */
// Processor status byte keeper and reserved opcode dispatch decoder.
`timescale 1ns/100ps

// Notes on behaviour
// - Status byte: gate bit 7, trace bit 4, N Z V C bits 3..0.
// - Flags update on data moves and arithmetic or logical operations.
// - Single and double operand data instructions set flags from result.
// - Data instructions never alter gate bit 7 or trace bit 4.
// - Branch, jump, subroutine and misc instructions leave status unchanged.
// - Trap and return instructions may load every working status bit.
// - Condition code operators set or clear selected flags; empty mask is nop.
// - Move-from-status copies byte; register mode sign extends bit 7.
// - After move-from-status N=bit7, Z=byte zero, V cleared, C kept.
// - Move-to-status loads all working bits but may only clear trace.
// - Four reserved opcode groups are recognised and handled per group.
// - Diagnostic 21R stores temporaries at R and leaves R modified.
// - Opcodes 220-227 dispatch to microaddress 3000.
// - Opcodes 075040-075777 dispatch to microaddress 3003.
// - Without enabled control store, dispatching opcodes trap through vector 10.
// - All 076XXX opcodes dispatch to 3001; 0767XX are user instructions.
// - Low six opcode bits pass unchanged to the microprogram.
// - R7 is the program counter, advanced by instruction word count.
// - Eight register modes plus four PC modes for source and destination.
// - R6 is the stack pointer for operands, traps and subroutines.
// - Trap pushes PC and status, then loads from vector pair.
module swd_status_dispatch (
	input wire logic clk,
	input wire logic reset,
	input wire logic decode_req,
	input wire logic [15:0] instr_word,
	input wire logic ucs_enable,
	input wire logic alu_flags_valid,
	input wire logic [3:0] alu_flags,
	input wire logic status_load_valid,
	input wire logic [7:0] status_load_byte,
	input wire logic move_to_status_valid,
	input wire logic [7:0] move_to_status_src,
	input wire logic trap_start,
	input wire logic [15:0] trap_vector_in,
	output logic [7:0] processor_status_byte_ff,
	output logic decode_done_ff,
	output swd_pkg::swd_decode_t decode_ff,
	output swd_pkg::swd_addr_t addr_ff,
	output logic [1:0] pc_words_ff,
	output logic [2:0] pc_reg_ff,
	output logic [2:0] stack_reg_ff,
	output logic uses_stack_ff,
	output logic [15:0] move_from_status_data_ff,
	output logic trap_push_ff,
	output logic [7:0] push_status_ff,
	output logic [15:0] new_pc_addr_ff,
	output logic [15:0] new_status_addr_ff
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// True when the word lies in the closed range lo..hi.
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// True when an operand needs an extra word after the instruction.
	function automatic logic needs_word(input logic [2:0] mode, input logic [2:0] rg);
		needs_word = (mode >= swd_pkg::MODE_INDEX) ||
			((rg == swd_pkg::REG_PC) && (mode == swd_pkg::MODE_AUTOINC ||
			mode == swd_pkg::MODE_AUTOINC_DEF));
	endfunction : needs_word

	////////////////////////////////////////////////////////////////////////////////
	// Instruction decode.

	swd_pkg::swd_decode_t nxt_decode;
	swd_pkg::swd_addr_t nxt_addr;
	logic [1:0] nxt_pc_words;
	logic nxt_uses_stack;
	logic is_move_from_status;
	logic is_ccop;
	logic is_double;

	// Classify the word, pick a dispatch target and describe its operands.
	always_comb begin
		nxt_decode = '0;
		nxt_decode.cls = swd_pkg::SWD_CLS_DATA;
		nxt_addr = '0;
		is_move_from_status = (instr_word & swd_pkg::OP_MASK_DD) == swd_pkg::OP_MOVE_FROM_STATUS;
		is_ccop = in_range(instr_word, swd_pkg::OP_CCOP_LO, swd_pkg::OP_CCOP_HI);
		is_double = (instr_word[14:12] != swd_pkg::DOUBLE_NONE) &&
			(instr_word[14:12] != swd_pkg::DOUBLE_EXT);
		nxt_decode.user_field = instr_word[5:0];
		if (in_range(instr_word, swd_pkg::OP_DIAG_LO, swd_pkg::OP_DIAG_HI)) begin
			// Diagnostic store; R is left advanced by the sequencer.
			nxt_decode.diag_store = 1'b1;
			nxt_decode.diag_reg = instr_word[2:0];
		end else if (in_range(instr_word, swd_pkg::OP_U3000_LO, swd_pkg::OP_U3000_HI)) begin
			nxt_decode.cls = swd_pkg::SWD_CLS_RESV;
			nxt_decode.micro_addr = swd_pkg::UADDR_3000;
		end else if (in_range(instr_word, swd_pkg::OP_U3003_LO, swd_pkg::OP_U3003_HI)) begin
			nxt_decode.cls = swd_pkg::SWD_CLS_RESV;
			nxt_decode.micro_addr = swd_pkg::UADDR_3003;
		end else if (in_range(instr_word, swd_pkg::OP_U3001_LO, swd_pkg::OP_U3001_HI)) begin
			nxt_decode.cls = swd_pkg::SWD_CLS_RESV;
			nxt_decode.micro_addr = swd_pkg::UADDR_3001;
			nxt_decode.user_defined = instr_word >= swd_pkg::OP_USER_LO;
		end else if (is_ccop || is_move_from_status ||
			(instr_word & swd_pkg::OP_MASK_DD) == swd_pkg::OP_MOVE_TO_STATUS) begin
			nxt_decode.cls = swd_pkg::SWD_CLS_STATUS;
		end else if (instr_word == swd_pkg::OP_RTI || instr_word == swd_pkg::OP_RTT ||
			instr_word == swd_pkg::OP_BPT || instr_word == swd_pkg::OP_IOT ||
			in_range(instr_word, swd_pkg::OP_EMT_LO, swd_pkg::OP_EMT_HI)) begin
			nxt_decode.cls = swd_pkg::SWD_CLS_TRAP;
		end else if (instr_word <= swd_pkg::OP_MISC_HI ||
			in_range(instr_word, swd_pkg::OP_JMP_LO, swd_pkg::OP_RTS_HI) ||
			in_range(instr_word, swd_pkg::OP_BR_LO, swd_pkg::OP_BR_HI) ||
			in_range(instr_word, swd_pkg::OP_JSR_LO, swd_pkg::OP_JSR_HI) ||
			in_range(instr_word, swd_pkg::OP_SOB_LO, swd_pkg::OP_SOB_HI) ||
			in_range(instr_word, swd_pkg::OP_BRB_LO, swd_pkg::OP_BRB_HI)) begin
			nxt_decode.cls = swd_pkg::SWD_CLS_CTRL;
		end
		// Dispatch only into an enabled store, otherwise trap.
		if (nxt_decode.cls == swd_pkg::SWD_CLS_RESV) begin
			nxt_decode.dispatch = ucs_enable;
			nxt_decode.resv_trap = !ucs_enable;
		end
		// Operand fields for the twelve addressing forms.
		nxt_addr.has_dst = (nxt_decode.cls == swd_pkg::SWD_CLS_DATA &&
			!nxt_decode.diag_store) ||
			(nxt_decode.cls == swd_pkg::SWD_CLS_STATUS && !is_ccop) ||
			in_range(instr_word, swd_pkg::OP_JMP_LO, swd_pkg::OP_JMP_LO | 16'h003F) ||
			in_range(instr_word, swd_pkg::OP_JSR_LO, swd_pkg::OP_JSR_HI);
		nxt_addr.has_src = nxt_decode.cls == swd_pkg::SWD_CLS_DATA && is_double;
		nxt_addr.dst_mode = instr_word[5:3];
		nxt_addr.dst_reg = instr_word[2:0];
		nxt_addr.src_mode = instr_word[11:9];
		nxt_addr.src_reg = instr_word[8:6];
		nxt_addr.dst_pc_rel = nxt_addr.has_dst && instr_word[2:0] == swd_pkg::REG_PC;
		nxt_addr.src_pc_rel = nxt_addr.has_src && instr_word[8:6] == swd_pkg::REG_PC;
	end

	// Words occupied by the instruction, counted for advancing R7.
	always_comb begin
		nxt_pc_words = 2'd1;
		if (nxt_addr.has_dst && needs_word(nxt_addr.dst_mode, nxt_addr.dst_reg)) begin
			nxt_pc_words = nxt_pc_words + 2'd1;
		end
		if (nxt_addr.has_src && needs_word(nxt_addr.src_mode, nxt_addr.src_reg)) begin
			nxt_pc_words = nxt_pc_words + 2'd1;
		end
	end

	// Stack pointer involvement: traps, subroutines or an R6 operand.
	always_comb begin
		nxt_uses_stack = (nxt_decode.cls == swd_pkg::SWD_CLS_TRAP) ||
			in_range(instr_word, swd_pkg::OP_JSR_LO, swd_pkg::OP_JSR_HI) ||
			in_range(instr_word, swd_pkg::OP_RTS_HI & ~16'h0007, swd_pkg::OP_RTS_HI) ||
			(nxt_addr.has_dst && nxt_addr.dst_reg == swd_pkg::REG_SP) ||
			(nxt_addr.has_src && nxt_addr.src_reg == swd_pkg::REG_SP);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode result registers.

	// Hold the decode of the most recent request; done pulses one cycle.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			decode_done_ff <= 1'b0;
			decode_ff <= '0;
			addr_ff <= '0;
			pc_words_ff <= 2'd0;
			uses_stack_ff <= 1'b0;
		end else begin
			decode_done_ff <= decode_req;
			if (decode_req) begin
				decode_ff <= nxt_decode;
				addr_ff <= nxt_addr;
				pc_words_ff <= nxt_pc_words;
				uses_stack_ff <= nxt_uses_stack;
			end
		end
	end

	// Dedicated register indices for the sequencer.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pc_reg_ff <= swd_pkg::REG_PC;
			stack_reg_ff <= swd_pkg::REG_SP;
		end else begin
			pc_reg_ff <= swd_pkg::REG_PC;
			stack_reg_ff <= swd_pkg::REG_SP;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status byte.

	localparam logic [7:0] STS_ZERO = 8'h00;
	logic [7:0] nxt_status;
	logic [7:0] sts;

	assign sts = processor_status_byte_ff;

	// Priority: trap/return load, then move-to, then decode effects, then ALU flags.
	always_comb begin
		nxt_status = sts;
		if (status_load_valid) begin
			nxt_status = status_load_byte;
		end else if (move_to_status_valid) begin
			nxt_status = move_to_status_src;
			nxt_status[swd_pkg::STS_TRACE_BIT] = move_to_status_src[swd_pkg::STS_TRACE_BIT] &
				sts[swd_pkg::STS_TRACE_BIT];
		end else if (decode_req && is_ccop) begin
			// Selected flags set or cleared; an empty mask changes nothing.
			if (instr_word[4]) begin
				nxt_status[3:0] = sts[3:0] | instr_word[3:0];
			end else begin
				nxt_status[3:0] = sts[3:0] & ~instr_word[3:0];
			end
		end else if (decode_req && is_move_from_status) begin
			nxt_status[swd_pkg::STS_N_BIT] = sts[swd_pkg::STS_GATE_BIT];
			nxt_status[swd_pkg::STS_Z_BIT] = sts == STS_ZERO;
			nxt_status[swd_pkg::STS_V_BIT] = 1'b0;
		end else if (alu_flags_valid && decode_ff.cls == swd_pkg::SWD_CLS_DATA) begin
			// Only the low nibble moves; control classes ignore flags.
			nxt_status[3:0] = alu_flags;
		end
		nxt_status = nxt_status & swd_pkg::STS_WORKING_MASK;
	end

	// Status register, cleared by system initialisation.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			processor_status_byte_ff <= swd_pkg::STS_RESET;
		end else begin
			processor_status_byte_ff <= nxt_status;
		end
	end

	// Move-from-status data, sign extended for register mode.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			move_from_status_data_ff <= 16'h0000;
		end else if (decode_req && is_move_from_status) begin
			if (instr_word[5:3] == swd_pkg::MODE_REG) begin
				move_from_status_data_ff <= {{8{sts[swd_pkg::STS_GATE_BIT]}}, sts};
			end else begin
				move_from_status_data_ff <= {8'h00, sts};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trap entry.

	logic trap_go;
	logic [15:0] trap_vec;

	assign trap_go = trap_start || (decode_req && nxt_decode.resv_trap);
	assign trap_vec = trap_start ? trap_vector_in : swd_pkg::RESV_VECTOR;

	// Push request with current status and the vector pair to load.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			trap_push_ff <= 1'b0;
			push_status_ff <= 8'h00;
			new_pc_addr_ff <= 16'h0000;
			new_status_addr_ff <= 16'h0000;
		end else begin
			trap_push_ff <= trap_go;
			if (trap_go) begin
				push_status_ff <= sts;
				new_pc_addr_ff <= trap_vec;
				new_status_addr_ff <= 16'(trap_vec + swd_pkg::VECTOR_STEP);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	property p_resv_zero;
		@(posedge clk) disable iff (reset) processor_status_byte_ff[6:5] == 2'b00;
	endproperty
	a_resv_zero: assert property (p_resv_zero)
		else $error("reserved status bits set");

	property p_alu_keeps_hi;
		@(posedge clk) disable iff (reset)
		(alu_flags_valid && !status_load_valid && !move_to_status_valid && !decode_req)
		|=> (processor_status_byte_ff[7:4] == $past(processor_status_byte_ff[7:4]));
	endproperty
	a_alu_keeps_hi: assert property (p_alu_keeps_hi)
		else $error("alu update hit bits 7..4");

	property p_ctrl_keeps;
		@(posedge clk) disable iff (reset)
		(decode_ff.cls == swd_pkg::SWD_CLS_CTRL && !status_load_valid && !move_to_status_valid &&
		!decode_req) |=> $stable(processor_status_byte_ff);
	endproperty
	a_ctrl_keeps: assert property (p_ctrl_keeps)
		else $error("control class changed status");

	property p_load_all;
		@(posedge clk) disable iff (reset)
		status_load_valid |=> processor_status_byte_ff == ($past(status_load_byte) & 8'h9F);
	endproperty
	a_load_all: assert property (p_load_all)
		else $error("status load mismatch");

	property p_move_to_status_trace;
		@(posedge clk) disable iff (reset)
		(move_to_status_valid && !status_load_valid && !processor_status_byte_ff[4])
		|=> !processor_status_byte_ff[4];
	endproperty
	a_move_to_status_trace: assert property (p_move_to_status_trace)
		else $error("move-to set trace");

	property p_move_from_status_flags;
		@(posedge clk) disable iff (reset)
		(decode_req && is_move_from_status && !status_load_valid && !move_to_status_valid) |=>
		(processor_status_byte_ff[3] == $past(processor_status_byte_ff[7]) &&
		!processor_status_byte_ff[1] &&
		processor_status_byte_ff[0] == $past(processor_status_byte_ff[0]));
	endproperty
	a_move_from_status_flags: assert property (p_move_from_status_flags)
		else $error("move-from flags wrong");

	property p_disp_3000;
		@(posedge clk) disable iff (reset)
		(decode_req && ucs_enable && instr_word[15:3] == 13'h0012) |=>
		(decode_done_ff && decode_ff.dispatch && decode_ff.micro_addr == 11'h600);
	endproperty
	a_disp_3000: assert property (p_disp_3000)
		else $error("220-227 not sent to 3000");

	property p_resv_trap;
		@(posedge clk) disable iff (reset)
		(decode_req && !ucs_enable && !trap_start && instr_word[15:9] == 7'h3E) |=>
		(trap_push_ff && !decode_ff.dispatch && new_pc_addr_ff == 16'h0008 &&
		new_status_addr_ff == 16'h000A);
	endproperty
	a_resv_trap: assert property (p_resv_trap)
		else $error("reserved trap not raised");

	property p_user_field;
		@(posedge clk) disable iff (reset)
		(decode_req && ucs_enable && instr_word[15:6] == 10'h1F7) |=>
		(decode_ff.user_defined && decode_ff.micro_addr == 11'h601 &&
		decode_ff.user_field == $past(instr_word[5:0]));
	endproperty
	a_user_field: assert property (p_user_field)
		else $error("user field not passed");

	property p_pc_words;
		@(posedge clk) disable iff (reset)
		(decode_req && instr_word[15:12] == 4'h1 && instr_word[11:9] == 3'h6 &&
		instr_word[5:3] == 3'h6) |=> pc_words_ff == 2'd3;
	endproperty
	a_pc_words: assert property (p_pc_words)
		else $error("index move word count wrong");

endmodule : swd_status_dispatch

/* verification/swd_ucs_model.sv */
// Behavioural model of the microsequencer and the optional user control store.
`timescale 1ns/100ps
module swd_ucs_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic present,
	input wire logic decode_done,
	input wire swd_pkg::swd_decode_t decode,
	output logic ucs_enable,
	output logic [10:0] entry_addr_ff,
	output logic [5:0] entry_data_ff
);
	// The store only answers while it is fitted and switched on.
	assign ucs_enable = present;
	////////////////////////////////////////////////////////////////////////////
	// Latch the entry microaddress and immediate bits of each dispatch taken.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			entry_addr_ff <= 11'h000;
			entry_data_ff <= 6'h00;
		end else if (decode_done && decode.dispatch && ucs_enable) begin
			entry_addr_ff <= decode.micro_addr;
			entry_data_ff <= decode.user_field;
		end
	end
endmodule : swd_ucs_model

/* verification/tb.sv */
// Self-checking testbench for the status word and opcode dispatch block.
`timescale 1ns/100ps
module tb;
	localparam int K_LOAD = 0;
	localparam int K_MOVE_TO_STATUS = 1;
	localparam int K_ALU = 2;
	localparam int K_TRAP = 3;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic decode_req = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic ucs_present = 1'b1;
	logic ucs_enable;
	logic alu_flags_valid = 1'b0;
	logic [3:0] alu_flags = 4'h0;
	logic status_load_valid = 1'b0;
	logic [7:0] status_load_byte = 8'h00;
	logic move_to_status_valid = 1'b0;
	logic [7:0] move_to_status_src = 8'h00;
	logic trap_start = 1'b0;
	logic [15:0] trap_vector_in = 16'h0000;
	logic [7:0] psb;
	logic done;
	swd_pkg::swd_decode_t dcd;
	swd_pkg::swd_addr_t adr;
	logic [1:0] pc_words;
	logic [2:0] pc_reg;
	logic [2:0] sp_reg;
	logic uses_stack;
	logic [15:0] move_from_status_data;
	logic trap_push;
	logic [7:0] push_status;
	logic [15:0] new_pc;
	logic [15:0] new_sts;
	logic [10:0] ucs_addr;
	logic [5:0] ucs_data;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [15:0] cc_op [5] = '{16'h00bf, 16'h00a0, 16'h00a5, 16'h00af, 16'h00b8};
	logic [15:0] cc_exp [5] = '{16'h009f, 16'h009f, 16'h009a, 16'h0090, 16'h0098};
	logic [15:0] ds_op [7] = '{16'h0090, 16'h0097, 16'h7a20, 16'h7bff, 16'h7c00, 16'h7dc0,
		16'h7dff};
	logic [15:0] ds_ua [7] = '{16'h0600, 16'h0600, 16'h0603, 16'h0603, 16'h0601, 16'h0601,
		16'h0601};
	logic [15:0] tr_op [3] = '{16'h0090, 16'h7a20, 16'h7dc5};

	swd_status_dispatch dut (.clk(clk), .reset(reset), .decode_req(decode_req),
		.instr_word(instr_word), .ucs_enable(ucs_enable), .alu_flags_valid(alu_flags_valid),
		.alu_flags(alu_flags), .status_load_valid(status_load_valid),
		.status_load_byte(status_load_byte), .move_to_status_valid(move_to_status_valid), .move_to_status_src(move_to_status_src),
		.trap_start(trap_start), .trap_vector_in(trap_vector_in),
		.processor_status_byte_ff(psb), .decode_done_ff(done), .decode_ff(dcd), .addr_ff(adr),
		.pc_words_ff(pc_words), .pc_reg_ff(pc_reg), .stack_reg_ff(sp_reg),
		.uses_stack_ff(uses_stack), .move_from_status_data_ff(move_from_status_data), .trap_push_ff(trap_push),
		.push_status_ff(push_status), .new_pc_addr_ff(new_pc), .new_status_addr_ff(new_sts));
	swd_ucs_model u_ucs (.clk(clk), .reset(reset), .present(ucs_present), .decode_done(done),
		.decode(dcd), .ucs_enable(ucs_enable), .entry_addr_ff(ucs_addr),
		.entry_data_ff(ucs_data));

	////////////////////////////////////////////////////////////////////////////
	// Free-running processor clock and a ceiling on the run length.
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare one observed value with its expectation.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Present one instruction word and return once its decode has landed.
	task automatic dec(input logic [15:0] op);
		@(posedge clk);
		decode_req <= 1'b1;
		instr_word <= op;
		@(posedge clk);
		decode_req <= 1'b0;
		#1;
		chk(done, 16'h0001);
	endtask : dec
	// Raise one single-cycle strobe with its value and let the result land.
	task automatic pulse(input int kind, input logic [15:0] val);
		@(posedge clk);
		status_load_valid <= (kind == K_LOAD);
		move_to_status_valid <= (kind == K_MOVE_TO_STATUS);
		alu_flags_valid <= (kind == K_ALU);
		trap_start <= (kind == K_TRAP);
		status_load_byte <= val[7:0];
		move_to_status_src <= val[7:0];
		alu_flags <= val[3:0];
		trap_vector_in <= val;
		@(posedge clk);
		status_load_valid <= 1'b0;
		move_to_status_valid <= 1'b0;
		alu_flags_valid <= 1'b0;
		trap_start <= 1'b0;
		#1;
	endtask : pulse
	// Print the counts and the verdict, then stop.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////
	// Main sequence of tests.
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk(psb, 16'h0000);
		chk(pc_reg, 16'h0007);
		chk(sp_reg, 16'h0006);
		pulse(K_MOVE_TO_STATUS, 16'h00ff);
		chk(psb, 16'h008f);
		pulse(K_LOAD, 16'h00ff);
		chk(psb, 16'h009f);
		pulse(K_MOVE_TO_STATUS, 16'h0060);
		chk(psb, 16'h0000);
		$display("test status writes done");
		pulse(K_LOAD, 16'h0090);
		for (int i = 0; i < 5; i++) begin
			dec(cc_op[i]);
			chk(psb, cc_exp[i]);
		end
		dec(16'h1000);
		chk(dcd.cls, 16'h0000);
		pulse(K_ALU, 16'h000a);
		chk(psb, 16'h009a);
		dec(16'h0100);
		pulse(K_ALU, 16'h0005);
		chk(psb, 16'h009a);
		dec(16'h09f7);
		chk(uses_stack, 16'h0001);
		chk(pc_words, 16'h0002);
		chk(psb, 16'h009a);
		$display("test flag classes done");
		pulse(K_LOAD, 16'h0083);
		dec(16'h8dc0);
		chk(move_from_status_data, 16'hff83);
		chk(psb, 16'h0089);
		pulse(K_LOAD, 16'h0081);
		dec(16'h8dc8);
		chk(move_from_status_data, 16'h0081);
		pulse(K_LOAD, 16'h0000);
		dec(16'h8dc0);
		chk(move_from_status_data, 16'h0000);
		chk(psb, 16'h0004);
		$display("test move from status done");
		for (int i = 0; i < 7; i++) begin
			dec(ds_op[i]);
			chk(dcd.dispatch, 16'h0001);
			chk(dcd.micro_addr, ds_ua[i]);
			chk(dcd.user_defined, {15'h0000, ds_op[i][15:6] == 10'h1f7});
			chk(trap_push, 16'h0000);
			@(posedge clk);
			#1;
			chk(ucs_addr, ds_ua[i]);
			if (ds_op[i][15:6] == 10'h1f7) chk(ucs_data, ds_op[i][5:0]);
		end
		dec(16'h7a1f);
		chk(dcd.dispatch, 16'h0000);
		dec(16'h008b);
		chk(dcd.diag_store, 16'h0001);
		chk(dcd.diag_reg, 16'h0003);
		chk(dcd.dispatch, 16'h0000);
		$display("test dispatch done");
		@(posedge clk);
		ucs_present <= 1'b0;
		pulse(K_LOAD, 16'h0091);
		for (int i = 0; i < 3; i++) begin
			dec(tr_op[i]);
			chk(dcd.resv_trap, 16'h0001);
			chk(trap_push, 16'h0001);
			chk(new_pc, 16'h0008);
			chk(new_sts, 16'h000a);
			chk(push_status, 16'h0091);
		end
		pulse(K_TRAP, 16'h0010);
		chk(trap_push, 16'h0001);
		chk(new_pc, 16'h0010);
		chk(new_sts, 16'h0012);
		$display("test traps done");
		dec(16'h15df);
		chk(pc_words, 16'h0003);
		chk(adr.src_pc_rel, 16'h0001);
		chk(adr.dst_pc_rel, 16'h0001);
		dec(16'h0a06);
		chk(pc_words, 16'h0001);
		chk(adr.has_src, 16'h0000);
		chk(uses_stack, 16'h0001);
		dec(16'h1c31);
		chk(pc_words, 16'h0003);
		dec(16'h0077);
		chk(uses_stack, 16'h0000);
		chk(pc_words, 16'h0002);
		$display("test addressing done");
		finish_test();
	end
endmodule : tb
